// File: core/cfm_pkg.sv
// constants and register map of the contactor feedback monitor
//
// Overview of operation
// R1 - A standby mode on the active field triple stops field monitoring and holds both safety outputs off.
// R2 - Field triple monitoring is switched by a setting, and only then is a mode chosen for the triple.
// R3 - Feedback checking runs only when enabled and then checks every switching edge of the outputs.
// R4 - The outputs switch on only when the feedback loop is seen closed first.
// R5 - After release the feedback loop must open within 500 ms of the release.
// R6 - After switch-off the feedback loop must close again within 500 ms.
// R7 - A failed timing check forces the safety outputs off again.
// R8 - With outputs off the feedback input must be high, otherwise the fault lock is entered.
// R9 - With outputs on the feedback loop must be open, otherwise the fault lock is entered.
// R10 - Events reach the indication outputs through a configurable assignment.
// R11 - The fault lock keeps the outputs off until a restart or a reset clears it.
package cfm_pkg;
   // clock and feedback timing
   localparam int CLK_HZ = 20000000;
   localparam int FB_WINDOW_MS = 500;
   localparam int FB_WINDOW_CYC = FB_WINDOW_MS * (CLK_HZ / 1000);
   localparam int TMR_W = 24;
   // register byte addresses
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] MODE_OFS = 8'h04;
   localparam logic [7:0] ROUTE_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   // control field positions
   localparam int CTRL_FMON_BIT = 0;
   localparam int CTRL_FB_BIT = 1;
   localparam int CTRL_RUN_BIT = 2;
   localparam int CTRL_RESTART_BIT = 7;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [23:0] ROUTE_RST = 24'h000000;
   // sizes
   localparam int N_EVT = 6;
   localparam int N_IND = 4;
   localparam int N_PIN = 10;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // feedback supervision states
   typedef enum logic [2:0] {
      ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT, ST_LOCK
   } cfm_state_t;
endpackage

// File: core/cfm_monitor.sv
// contactor feedback monitor with standby mode and indication routing
`timescale 1ns/10ps
module cfm_monitor import cfm_pkg::*; #(
   parameter int FB_WINDOW = FB_WINDOW_CYC
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // pins
   input wire logic contactor_feedback_input_i,
   input wire logic [2:0] field_triple_i,
   input wire logic prot_field_viol_i,
   input wire logic warn_field_viol_i,
   input wire logic dev_func_i,
   input wire logic error_evt_i,
   input wire logic warning_evt_i,
   input wire logic diag_evt_i,
   output logic safety_switching_output_a_o,
   output logic safety_switching_output_b_o,
   output logic field_mon_active_o,
   output logic [3:0] indication_o,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i
);
   logic [N_PIN-1:0] pin_raw;
   logic [N_PIN-1:0] meta_q;
   logic [N_PIN-1:0] sync_q;
   logic fb_q;
   logic [2:0] triple_q;
   logic [N_EVT-1:0] evt_q;
   logic [7:0] ctrl_q;
   logic [7:0] mode_q;
   logic [23:0] route_q;
   logic restart_q;
   logic standby_q;
   logic standby_now;
   cfm_state_t state_q;
   cfm_state_t state_d;
   logic [TMR_W-1:0] tmr_q;
   logic on_req;
   logic fb_en;
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_en;
   logic [31:0] wmask;
   logic wr_hit;
   logic [31:0] rd_val;
   logic rd_hit;

   // two-stage synchronisers for every pin input
   assign pin_raw = {diag_evt_i, warning_evt_i, error_evt_i, dev_func_i,
                     warn_field_viol_i, prot_field_viol_i, field_triple_i,
                     contactor_feedback_input_i};
   genvar gi;
   generate
      for (gi = 0; gi < N_PIN; gi++) begin : g_sync
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= pin_raw[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate
   assign fb_q = sync_q[0];  // high: loop closed, supply present
   assign triple_q = sync_q[3:1];
   assign evt_q = sync_q[9:4];

   // axi write channel capture, address and data in either order
   assign wr_en = aw_have_q & w_have_q & ~s_axi_bvalid_o;
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o <= 1'b1;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else begin
         if (s_axi_awready_o && s_axi_awvalid_i) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wready_o && s_axi_wvalid_i) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_en) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
         end
      end
   end

   // byte lanes and address decode for writes
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                   {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_hit = (awaddr_q == CTRL_OFS) || (awaddr_q == MODE_OFS) ||
                   (awaddr_q == ROUTE_OFS) || (awaddr_q == STAT_OFS);

   // writable configuration registers; restart bit is a one-shot
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ctrl_q <= CTRL_RST;
         mode_q <= MODE_RST;
         route_q <= ROUTE_RST;
         restart_q <= 1'b0;
      end else begin
         restart_q <= 1'b0;
         if (wr_en && awaddr_q == CTRL_OFS && wstrb_q[0]) begin
            ctrl_q <= {1'b0, wdata_q[6:0]};
            restart_q <= wdata_q[CTRL_RESTART_BIT];
         end
         if (wr_en && awaddr_q == MODE_OFS && wstrb_q[0]) begin
            mode_q <= wdata_q[7:0];
         end
         if (wr_en && awaddr_q == ROUTE_OFS) begin
            route_q <= (route_q & ~wmask[23:0]) |
                       (wdata_q[23:0] & wmask[23:0]);
         end
      end
   end

   // read decode, status shows live supervision state
   always_comb begin
      rd_val = 32'h00000000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr_i)
         CTRL_OFS: rd_val = {24'h000000, ctrl_q};
         MODE_OFS: rd_val = {24'h000000, mode_q};
         ROUTE_OFS: rd_val = {8'h00, route_q};
         STAT_OFS: rd_val = {24'h000000, 1'b0, triple_q,
                             standby_q, fb_q,
                             (state_q == ST_LOCK),
                             safety_switching_output_a_o};
         default: rd_hit = 1'b0;
      endcase
   end

   // axi read channel, answer one cycle after the address is taken
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (s_axi_arready_o && s_axi_arvalid_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_val;
         s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // standby request seen in the same cycle, so no one-cycle on pulse
   assign standby_now = ctrl_q[CTRL_FMON_BIT] & mode_q[triple_q];  // [R2]

   // standby mode only when field triple monitoring is enabled
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         standby_q <= 1'b0;
         field_mon_active_o <= 1'b0;
      end else begin
         standby_q <= standby_now;  // [R2]
         field_mon_active_o <= ctrl_q[CTRL_FMON_BIT] &
                               ~(mode_q[triple_q]);  // [R1] [R2]
      end
   end

   // switch-on request: software run, free field, no standby
   assign on_req = ctrl_q[CTRL_RUN_BIT] & ~evt_q[0] & ~standby_now;  // [R1]
   assign fb_en = ctrl_q[CTRL_FB_BIT];

   // feedback supervision next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_OFF: begin
            if (fb_en && !fb_q) begin
               state_d = ST_LOCK;  // [R8]
            end else if (on_req) begin
               state_d = fb_en ? ST_ON_WAIT : ST_ON;  // [R3] [R4]
            end
         end
         ST_ON_WAIT: begin
            if (!on_req) begin
               state_d = ST_OFF_WAIT;  // [R3]
            end else if (!fb_q) begin
               state_d = ST_ON;
            end else if (fb_en && tmr_q == '0) begin
               state_d = ST_LOCK;  // [R5] [R7]
            end
         end
         ST_ON: begin
            if (!on_req) begin
               state_d = fb_en ? ST_OFF_WAIT : ST_OFF;
            end else if (fb_en && fb_q) begin
               state_d = ST_LOCK;  // [R9]
            end
         end
         ST_OFF_WAIT: begin
            if (fb_q || !fb_en) begin
               state_d = ST_OFF;  // [R3]
            end else if (tmr_q == '0) begin
               state_d = ST_LOCK;  // [R6]
            end
         end
         ST_LOCK: begin
            if (restart_q) begin
               state_d = ST_OFF;  // [R11]
            end
         end
         default: state_d = ST_LOCK;
      endcase
   end

   // state, window timer and the paired safety outputs
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_q <= ST_OFF;
         tmr_q <= '0;
         safety_switching_output_a_o <= 1'b0;
         safety_switching_output_b_o <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            tmr_q <= TMR_W'(FB_WINDOW - 1);  // [R5] [R6]
         end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
         end
         safety_switching_output_a_o <= (state_d == ST_ON_WAIT) ||
                                        (state_d == ST_ON);  // [R7] [R11]
         safety_switching_output_b_o <= (state_d == ST_ON_WAIT) ||
                                        (state_d == ST_ON);
      end
   end

   // event routing: one six-bit mask per indication output
   generate
      for (gi = 0; gi < N_IND; gi++) begin : g_ind
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               indication_o[gi] <= 1'b0;
            end else begin
               // [R10]
               indication_o[gi] <= |(evt_q & route_q[gi*N_EVT +: N_EVT]);
            end
         end
      end
   endgenerate

   // checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   // standby and monitoring enable
   a_standby_holds_off: assert property ( // [R1]
      standby_q |->
      !safety_switching_output_a_o)
      else $error("outputs on in standby");

   a_mon_gates_mode: assert property ( // [R2]
      !ctrl_q[CTRL_FMON_BIT] |=>
      !standby_q)
      else $error("standby without monitoring");

   // feedback supervision
   a_no_fb_lock: assert property ( // [R3]
      !fb_en && state_q != ST_LOCK |=>
      state_q != ST_LOCK)
      else $error("lock with checking off");

   a_on_needs_closed: assert property ( // [R4]
      $rose(safety_switching_output_a_o) && $past(fb_en) |->
      $past(fb_q))
      else $error("switched on with open loop");

   a_open_window: assert property ( // [R5] [R7]
      state_q == ST_ON_WAIT && on_req && fb_en && fb_q && tmr_q == '0 |=>
      state_q == ST_LOCK ##1 !safety_switching_output_a_o)
      else $error("open timeout missed");

   a_close_window: assert property ( // [R6]
      state_q == ST_OFF_WAIT && fb_en && !fb_q && tmr_q == '0 |=>
      state_q == ST_LOCK)
      else $error("close timeout missed");

   a_off_needs_high: assert property ( // [R8]
      state_q == ST_OFF && fb_en && !fb_q |=>
      state_q == ST_LOCK)
      else $error("low feedback while off");

   a_on_needs_open: assert property ( // [R9]
      state_q == ST_ON && on_req && fb_en && fb_q |=>
      state_q == ST_LOCK)
      else $error("closed loop while on");

   // routing, lock and equal safety output pair
   a_route_map: assert property ( // [R10]
      ##1 indication_o[0] ==
      |($past(evt_q) & $past(route_q[5:0])))
      else $error("indication routing wrong");

   a_lock_holds: assert property ( // [R11]
      state_q == ST_LOCK && !restart_q |=>
      state_q == ST_LOCK && !safety_switching_output_a_o)
      else $error("lock released");

   a_pair_equal: assert property (
      safety_switching_output_a_o == safety_switching_output_b_o)
      else $error("outputs differ");

   // main scenarios
   c_switch_on: cover property (state_q == ST_ON_WAIT ##1 state_q == ST_ON);
   c_clean_off: cover property (state_q == ST_OFF_WAIT ##1 state_q == ST_OFF);
   c_lock_restart: cover property (state_q == ST_LOCK ##1 state_q == ST_OFF);
   c_standby: cover property (standby_q && ctrl_q[CTRL_RUN_BIT]);
   c_on_lock: cover property (state_q == ST_ON ##1 state_q == ST_LOCK);
endmodule

// File: verification/cfm_contactor_model.sv
// contactor with positive-guided feedback contact, optionally welded
`timescale 1ns/10ps
module cfm_contactor_model (
   input wire logic clk_sys_i,
   input wire logic coil_i,
   input wire logic [7:0] dly_i,
   input wire logic fault_i,
   output logic fb_o
);
   logic [7:0] cnt_q;
   initial begin
      fb_o = 1'b1;
      cnt_q = 8'h00;
   end
   // contact moves dly_i + 1 cycles after the coil changes
   always @(posedge clk_sys_i) begin
      if (fault_i) begin
         fb_o <= coil_i; // welded: loop level follows the coil wrongly
         cnt_q <= 8'h00;
      end else if (fb_o == coil_i) begin
         // closed while off, open while on
         if (cnt_q >= dly_i) begin
            fb_o <= !coil_i;
            cnt_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end else begin
         cnt_q <= 8'h00;
      end
   end
endmodule

// File: verification/tb_top.sv
// self-checking bench of the contactor feedback monitor
`timescale 1ns/10ps
module tb_top import cfm_pkg::*;;
   typedef struct {
      logic [31:0] d; logic [1:0] r; logic c; logic on; logic fm;
   } cfm_exp_t;
   cfm_exp_t rq[$];
   logic [1:0] bq[$];
   logic clk_sys = 1'b0, srst = 1'b1, fb, fault = 1'b0;
   logic [7:0] dly = 8'h05, awaddr = 8'h00, araddr = 8'h00;
   logic [2:0] tri_sel = 3'h0;
   logic [5:0] ev = 6'h00;
   logic [23:0] route_m = 24'h000000;
   logic [31:0] wdata = 32'h0, rdata, rnd = 32'h70b6f3a8;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, ssa, ssb, fma;
   logic [1:0] bresp, rresp;
   logic [3:0] ind;
   int errors = 0, n_checks = 0, cyc = 0;
   always #25 clk_sys = ~clk_sys;
   cfm_monitor #(.FB_WINDOW(20)) DUT (.clk_sys_i(clk_sys), .srst_i(srst),
      .contactor_feedback_input_i(fb), .field_triple_i(tri_sel),
      .prot_field_viol_i(ev[0]), .warn_field_viol_i(ev[1]),
      .dev_func_i(ev[2]), .error_evt_i(ev[3]), .warning_evt_i(ev[4]),
      .diag_evt_i(ev[5]), .safety_switching_output_a_o(ssa),
      .safety_switching_output_b_o(ssb), .field_mon_active_o(fma),
      .indication_o(ind), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready));
   cfm_contactor_model u_cont (.clk_sys_i(clk_sys), .coil_i(ssa),
      .dly_i(dly), .fault_i(fault), .fb_o(fb));
   // comparisons, one task for each kind of result
   task automatic cmp_d(string n, logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cmp_r(string n, logic [1:0] e, logic [1:0] s);
      cmp_d(n, {30'h0, e}, {30'h0, s});
   endtask
   task automatic cmp_p(string n, logic [6:0] e, logic [6:0] s);
      cmp_d(n, {25'h0, e}, {25'h0, s});
   endtask
   function automatic logic [3:0] ind_f();
      logic [3:0] v;
      for (int k = 0; k < 4; k++) v[k] = |(ev & route_m[6*k +: 6]);
      return v;
   endfunction
   // oldest note is compared when a bus answer appears
   always @(posedge clk_sys) begin : mon
      cfm_exp_t e;
      if (rvalid && rready && rq.size() > 0) begin
         e = rq.pop_front();
         cmp_r("rresp", e.r, rresp);
         if (e.c) cmp_d("rdata", e.d, rdata);
         cmp_p("pins", {e.on, e.on, e.fm, ind_f()}, {ssa, ssb, fma, ind});
      end
      if (bvalid && bready && bq.size() > 0)
         cmp_r("bresp", bq.pop_front(), bresp);
   end
   // axi4-lite write, address and data offered together
   task automatic wr(logic [7:0] a, logic [31:0] d,
                     logic [1:0] r = RESP_OKAY);
      bq.push_back(r);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!(bvalid && bready));
      bready <= 0;
      @(posedge clk_sys);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] r,
                     logic c, logic on, logic fm);
      cfm_exp_t e;
      e = '{d, r, c, on, fm};
      rq.push_back(e);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 0;
      end while (!(rvalid && rready));
      rready <= 0;
      @(posedge clk_sys);
   endtask
   // expected status word: on, lock, feedback, standby, triple
   function automatic logic [31:0] st(logic o, logic l, logic f, logic s);
      return {25'h0, tri_sel, s, f, l, o};
   endfunction
   task automatic stat(logic o, logic l, logic f, logic s, logic fm = 0);
      rd(STAT_OFS, st(o, l, f, s), RESP_OKAY, 1, o, fm);
   endtask
   task automatic cy(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic tend(string n);
      $display("test %s done", n);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      cy(20);
      srst <= 0;
      rd(CTRL_OFS, 32'h0, RESP_OKAY, 1, 0, 0);
      rd(MODE_OFS, 32'h0, RESP_OKAY, 1, 0, 0);
      rd(ROUTE_OFS, 32'h0, RESP_OKAY, 1, 0, 0);
      rd(8'h10, 32'h0, RESP_SLVERR, 0, 0, 0);
      wr(8'h10, 32'h1, RESP_SLVERR);
      tend("reset");
      wr(CTRL_OFS, 32'h06); cy(12);
      stat(1, 0, 0, 0);
      wr(CTRL_OFS, 32'h02); cy(12);
      stat(0, 0, 1, 0);
      dly <= 8'd40; wr(CTRL_OFS, 32'h04); cy(30);
      stat(1, 0, 1, 0);
      wr(CTRL_OFS, 32'h00); cy(45);
      wr(CTRL_OFS, 32'h06); cy(30);
      stat(0, 1, 1, 0);
      cy(10);
      stat(0, 1, 1, 0);
      wr(CTRL_OFS, 32'h82);
      stat(0, 0, 1, 0);
      tend("release window");
      dly <= 8'd5; wr(CTRL_OFS, 32'h06); cy(12);
      dly <= 8'd40; wr(CTRL_OFS, 32'h02); cy(28);
      stat(0, 1, 0, 0);
      cy(20); dly <= 8'd5; wr(CTRL_OFS, 32'h82);
      wr(CTRL_OFS, 32'h06); cy(12);
      fault <= 1; cy(8);
      stat(0, 1, 0, 0);
      wr(CTRL_OFS, 32'h82); cy(4);
      stat(0, 1, 0, 0);
      fault <= 0; cy(10); wr(CTRL_OFS, 32'h82);
      tend("feedback faults");
      rnd ^= rnd << 13; rnd ^= rnd >> 17; rnd ^= rnd << 5;
      tri_sel <= rnd[2:0]; cy(1);
      wr(MODE_OFS, 32'h1 << tri_sel); wr(CTRL_OFS, 32'h07); cy(8);
      stat(0, 0, 1, 1, 0);
      wr(MODE_OFS, 32'h0); cy(12);
      stat(1, 0, 0, 0, 1);
      wr(MODE_OFS, 32'h1 << tri_sel); wr(CTRL_OFS, 32'h06); cy(16);
      stat(1, 0, 0, 0, 0);
      ev <= 6'h01; cy(14);
      stat(0, 0, 1, 0);
      ev <= 6'h00; wr(CTRL_OFS, 32'h02); cy(12);
      tend("standby");
      for (int i = 0; i < 4; i++) begin
         rnd ^= rnd << 13; rnd ^= rnd >> 17; rnd ^= rnd << 5;
         route_m = rnd[23:0];
         wr(ROUTE_OFS, {8'h0, rnd[23:0]});
         ev <= rnd[29:24] & 6'h3e; cy(5);
         rd(ROUTE_OFS, {8'h0, route_m}, RESP_OKAY, 1, 0, 0);
      end
      tend("routing");
      end_of_test();
   end
endmodule
